// *** logic/media_seq_issuer.sv ***
// apb-controlled issuer of the media pipeline setup command stream
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
module media_seq_issuer (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // command stream toward the device
  output logic cmd_valid_o,
  output media_seq_pkg::cmd_s cmd_o,
  input wire logic cmd_ready_i
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SEND = 3'b010,
    S_WAIT = 3'b100
  } state_e;
  state_e state;
  logic [31:0] ctrl;
  logic [31:0] ind_addr;
  logic [31:0] ind_size;
  logic [7:0] obj_count;
  logic [7:0] obj_sent;
  logic [4:0] step;
  logic err;
  logic flushed;
  logic cb_seen;
  logic [31:0] rdata;
  logic [31:0] vcount;
  media_seq_pkg::cmd_s step_cmd;
  logic step_skip;
  wire logic wr = psel_i & penable_i & pwrite_i;
  wire logic rd_en = psel_i & ~penable_i & ~pwrite_i;
  wire logic go = wr && paddr_i == media_seq_pkg::OFF_CTRL
    && pwdata_i[media_seq_pkg::CTRL_GO] && state == S_IDLE;
  wire logic older = ctrl[media_seq_pkg::CTRL_OLDER];
  wire logic ind = ctrl[media_seq_pkg::CTRL_INDIRECT] & older;
  wire logic hs = cmd_valid_o & cmd_ready_i;
  wire logic [31:0] entries = {31'h0, ctrl[media_seq_pkg::CTRL_CSENTRY]};
  // [RULE_15] size multiple of 32 bytes
  wire logic size_bad = pwdata_i[media_seq_pkg::CTRL_INDIRECT]
    & pwdata_i[media_seq_pkg::CTRL_OLDER] & (ind_size[4:0] != 5'h00);
  assign vcount = {5'h00, ind_size[31:5]};
  // [RULE_04] fixed program in stage order
  always_comb begin
    step_cmd = '0;
    step_skip = 1'b0;
    unique case (step)
      // [RULE_03] base address early
      5'd0: begin
        step_cmd.op = media_seq_pkg::CMD_BASE_ADDR;
        step_cmd.arg0 = ind_addr;
      end
      // [RULE_20] stats off
      5'd1: begin
        step_cmd.op = media_seq_pkg::CMD_STATS_EN;
        step_skip = ~ctrl[media_seq_pkg::CTRL_MIXED];
      end
      // [RULE_06] disable vertex cache
      5'd2: begin
        step_cmd.op = media_seq_pkg::CMD_LOAD_REG;
        step_cmd.arg0 = media_seq_pkg::VC_REG_ADDR;
        step_cmd.arg1 = media_seq_pkg::VC_DISABLE;
        step_skip = ~older;
      end
      // [RULE_05] mandatory flush
      5'd3: step_cmd.op = media_seq_pkg::CMD_FLUSH;
      // [RULE_06] re-enable for indirect
      5'd4: begin
        step_cmd.op = media_seq_pkg::CMD_LOAD_REG;
        step_cmd.arg0 = media_seq_pkg::VC_REG_ADDR;
        step_cmd.arg1 = media_seq_pkg::VC_ENABLE;
        step_skip = ~ind;
      end
      // [RULE_07] setup state zero entries
      5'd5: begin
        step_cmd.op = media_seq_pkg::CMD_SETUP_STATE;
        step_skip = ~ctrl[media_seq_pkg::CTRL_FROM3D];
      end
      // [RULE_07] all 3d fences zero
      5'd6: begin
        step_cmd.op = media_seq_pkg::CMD_FENCE;
        step_skip = ~ctrl[media_seq_pkg::CTRL_FROM3D];
      end
      // [RULE_02] fence before first select
      5'd7: begin
        step_cmd.op = media_seq_pkg::CMD_FENCE;
        step_cmd.arg0 = {31'h0, ctrl[media_seq_pkg::CTRL_CSENTRY]};
        step_skip = ~ctrl[media_seq_pkg::CTRL_NEWCTX];
      end
      5'd8: step_cmd.op = media_seq_pkg::CMD_SELECT;
      // [RULE_08] [RULE_09] one fence after select
      5'd9: begin
        step_cmd.op = media_seq_pkg::CMD_FENCE;
        step_cmd.arg0 = {31'h0, ctrl[media_seq_pkg::CTRL_CSENTRY]};
      end
      // [RULE_10] base address leads state
      5'd10: begin
        step_cmd.op = media_seq_pkg::CMD_BASE_ADDR;
        step_cmd.arg0 = ind_addr;
      end
      // [RULE_11] media pointers
      5'd11: step_cmd.op = media_seq_pkg::CMD_MEDIA_PTRS;
      // [RULE_12] entry count zero or one
      5'd12: begin
        step_cmd.op = media_seq_pkg::CMD_STREAMER_STATE;
        step_cmd.arg0 = entries;
      end
      // [RULE_13] fixed vertex elements
      5'd13: begin
        step_cmd.op = media_seq_pkg::CMD_VERTEX_ELEM;
        step_cmd.arg0 = media_seq_pkg::VE_FORMAT;
        step_cmd.arg1 = media_seq_pkg::VE1_OFFSET;
        step_skip = ~ind;
      end
      // [RULE_14] single buffer pitch
      5'd14: begin
        step_cmd.op = media_seq_pkg::CMD_VERTEX_BUF;
        step_cmd.arg0 = ind_addr;
        step_cmd.arg1 = media_seq_pkg::VB_PITCH;
        step_skip = ~ind;
      end
      // [RULE_16] one constant buffer
      5'd15: begin
        step_cmd.op = media_seq_pkg::CMD_CONST_BUF;
        step_skip = ~ind | cb_seen;
      end
      // [RULE_17] [RULE_18] draw before objects
      5'd16: begin
        step_cmd.op = media_seq_pkg::CMD_DRAW;
        step_cmd.arg0 = media_seq_pkg::TOPO_POINTS;
        step_cmd.arg1 = vcount;
        step_skip = ~ind;
      end
      // [RULE_19] media objects repeat
      5'd17: begin
        step_cmd.op = media_seq_pkg::CMD_MEDIA_OBJ;
        step_cmd.arg0 = ind_addr;
        step_cmd.arg1 = ind_size;
        step_skip = (obj_count == 8'h00);
      end
      default: step_skip = 1'b1;
    endcase
  end
  wire logic last_obj = (step == 5'd17) && (obj_sent + 8'h01 >= obj_count);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      step <= 5'd0;
      obj_sent <= 8'h00;
      cmd_valid_o <= 1'b0;
      cmd_o <= '0;
      flushed <= 1'b0;
      cb_seen <= 1'b0;
    end else begin
      unique case (state)
        S_IDLE: if (go) begin
          state <= S_SEND;
          step <= 5'd0;
          obj_sent <= 8'h00;
          flushed <= 1'b0;
        end
        S_SEND: begin
          if (step >= 5'd18) begin
            state <= S_IDLE;
          end else if (!cmd_valid_o && !step_skip) begin
            cmd_valid_o <= 1'b1;
            cmd_o <= step_cmd;
            state <= S_WAIT;
          end else if (step_skip) begin
            step <= step + 5'd1;
          end
        end
        S_WAIT: if (hs) begin
          cmd_valid_o <= 1'b0;
          state <= S_SEND;
          // [RULE_01] track flush before state
          if (cmd_o.op == media_seq_pkg::CMD_FLUSH) begin
            flushed <= 1'b1;
            cb_seen <= 1'b0;
          end
          if (cmd_o.op == media_seq_pkg::CMD_CONST_BUF) cb_seen <= 1'b1;
          if (step == 5'd17 && !last_obj) begin
            obj_sent <= obj_sent + 8'h01;
          end else begin
            step <= step + 5'd1;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
  // [RULE_21] sticky error
  wire logic state_op = hs && (cmd_o.op == media_seq_pkg::CMD_MEDIA_PTRS);
  always_ff @(posedge clk_i) begin
    if (rst_i) err <= 1'b0;
    else if (go && size_bad) err <= 1'b1;
    else if (state_op && !flushed) err <= 1'b1;
    else if (wr && paddr_i == media_seq_pkg::OFF_STATUS
      && pwdata_i[media_seq_pkg::STAT_ERR]) err <= 1'b0;
  end
  // apb registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= media_seq_pkg::CTRL_RESET;
      ind_addr <= 32'h0000_0000;
      ind_size <= 32'h0000_0000;
      obj_count <= 8'h00;
    end else if (wr && state == S_IDLE) begin
      if (paddr_i == media_seq_pkg::OFF_CTRL) ctrl <= pwdata_i;
      if (paddr_i == media_seq_pkg::OFF_ADDR) ind_addr <= pwdata_i;
      if (paddr_i == media_seq_pkg::OFF_SIZE) ind_size <= pwdata_i;
      if (paddr_i == media_seq_pkg::OFF_COUNT) obj_count <= pwdata_i[7:0];
    end
  end
  always_comb begin
    unique case (paddr_i)
      media_seq_pkg::OFF_CTRL: rdata = ctrl & 32'hFFFF_FFFE;
      media_seq_pkg::OFF_STATUS: rdata = {30'h0, err, state != S_IDLE};
      media_seq_pkg::OFF_ADDR: rdata = ind_addr;
      media_seq_pkg::OFF_SIZE: rdata = ind_size;
      media_seq_pkg::OFF_COUNT: rdata = {24'h0, obj_count};
      default: rdata = 32'h0000_0000;
    endcase
  end
  wire logic known = paddr_i == media_seq_pkg::OFF_CTRL
    || paddr_i == media_seq_pkg::OFF_STATUS
    || paddr_i == media_seq_pkg::OFF_ADDR
    || paddr_i == media_seq_pkg::OFF_SIZE
    || paddr_i == media_seq_pkg::OFF_COUNT;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~known;
      if (rd_en) prdata_o <= rdata;
    end
  end
  // [RULE_03] context trackers for checks
  logic base_seen;
  logic cs_grant;
  always_ff @(posedge clk_i) begin
    if (rst_i || go) begin
      base_seen <= 1'b0;
      cs_grant <= 1'b0;
    end else if (hs) begin
      if (cmd_o.op == media_seq_pkg::CMD_BASE_ADDR) base_seen <= 1'b1;
      if (cmd_o.op == media_seq_pkg::CMD_FENCE) cs_grant <= cmd_o.arg0[0];
    end
  end
  // [RULE_08] select followed by fence
  property p_select_fence;
    @(posedge clk_i) disable iff (rst_i)
    (hs && cmd_o.op == media_seq_pkg::CMD_SELECT) |=>
      !cmd_valid_o ##[1:40] (cmd_valid_o &&
      cmd_o.op == media_seq_pkg::CMD_FENCE);
  endproperty
  a_select_fence: assert property (p_select_fence) // [RULE_08]
    else $error("select not followed by fence");
  // [RULE_12] entries zero or one
  property p_entries;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_STREAMER_STATE)
      |-> cmd_o.arg0 == {31'h0, cs_grant};
  endproperty
  a_entries: assert property (p_entries) // [RULE_12]
    else $error("streamer entry count out of range");
  // [RULE_14] pitch fixed
  property p_pitch;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_VERTEX_BUF)
      |-> cmd_o.arg1 == media_seq_pkg::VB_PITCH;
  endproperty
  a_pitch: assert property (p_pitch) // [RULE_14]
    else $error("vertex buffer pitch wrong");
  // [RULE_01] flushed before pointers
  property p_flush_first;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_MEDIA_PTRS)
      |-> flushed;
  endproperty
  a_flush_first: assert property (p_flush_first) // [RULE_01]
    else $error("state change without flush");
  // [RULE_17] draw topology
  property p_draw;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_DRAW)
      |-> cmd_o.arg0 == media_seq_pkg::TOPO_POINTS
        && cmd_o.arg1 == {5'h00, ind_size[31:5]};
  endproperty
  a_draw: assert property (p_draw) // [RULE_17]
    else $error("draw fields wrong");
  // [RULE_16] single constant buffer
  property p_one_cb;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_CONST_BUF) |-> !cb_seen;
  endproperty
  a_one_cb: assert property (p_one_cb) // [RULE_16]
    else $error("second constant buffer");
  // [RULE_06] cache register writes
  property p_loadreg;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_LOAD_REG)
      |-> cmd_o.arg0 == media_seq_pkg::VC_REG_ADDR;
  endproperty
  a_loadreg: assert property (p_loadreg) // [RULE_06]
    else $error("wrong cache register");
  // [RULE_21] error sticks
  property p_err_sticky;
    @(posedge clk_i) disable iff (rst_i)
    (err && !wr) |=> err;
  endproperty
  a_err_sticky: assert property (p_err_sticky) // [RULE_21]
    else $error("error flag dropped");
  // [RULE_04] command held until taken
  property p_cmd_hold;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && !cmd_ready_i) |=> cmd_valid_o && $stable(cmd_o);
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) // [RULE_04]
    else $error("command changed before taken");
  // [RULE_03] base address before select
  property p_base_first;
    @(posedge clk_i) disable iff (rst_i)
    (hs && cmd_o.op == media_seq_pkg::CMD_SELECT) |-> base_seen;
  endproperty
  a_base_first: assert property (p_base_first) // [RULE_03]
    else $error("select before base address");
  // [RULE_05] flush before select
  property p_flush_select;
    @(posedge clk_i) disable iff (rst_i)
    (hs && cmd_o.op == media_seq_pkg::CMD_SELECT) |-> flushed;
  endproperty
  a_flush_select: assert property (p_flush_select) // [RULE_05]
    else $error("select without flush stage");
  // [RULE_13] vertex element fields
  property p_vertex_elem;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_VERTEX_ELEM)
      |-> cmd_o.arg0 == media_seq_pkg::VE_FORMAT
        && cmd_o.arg1 == media_seq_pkg::VE1_OFFSET;
  endproperty
  a_vertex_elem: assert property (p_vertex_elem) // [RULE_13]
    else $error("vertex element fields wrong");
  // [RULE_16] constant buffer before draw
  property p_cb_before_draw;
    @(posedge clk_i) disable iff (rst_i)
    (cmd_valid_o && cmd_o.op == media_seq_pkg::CMD_DRAW) |-> cb_seen;
  endproperty
  a_cb_before_draw: assert property (p_cb_before_draw) // [RULE_16]
    else $error("draw without constant buffer");
  // [RULE_15] bad size flagged
  property p_size_err;
    @(posedge clk_i) disable iff (rst_i)
    (go && pwdata_i[media_seq_pkg::CTRL_INDIRECT]
      && pwdata_i[media_seq_pkg::CTRL_OLDER]
      && ind_size[4:0] != 5'h00) |=> err;
  endproperty
  a_size_err: assert property (p_size_err) // [RULE_15]
    else $error("bad indirect size not flagged");
endmodule // media_seq_issuer

// *** logic/media_seq_pkg.sv ***
// constants and types for the media command sequence issuer
// Functional notes
// [RULE_01] every state change preceded by a flush
// [RULE_02] fence before first select per context
// [RULE_03] base address before first select
// [RULE_04] issued stages strictly in stage order
// [RULE_05] flush stage is mandatory
// [RULE_06] cache disable, flush, optional re-enable writes
// [RULE_07] 3d-to-media: setup state, zero fences
// [RULE_08] select always followed by fence
// [RULE_09] at most one fence in fence stage
// [RULE_10] base address first in state stage
// [RULE_11] media state pointers at least once
// [RULE_12] streamer entries zero or one
// [RULE_13] two fixed vertex elements
// [RULE_14] one vertex buffer, pitch 0x20
// [RULE_15] indirect size multiple of 32 bytes
// [RULE_16] one constant buffer between flushes
// [RULE_17] fixed point-list draw fields
// [RULE_18] draw precedes media objects it feeds
// [RULE_19] any number of media objects
// [RULE_20] stats off before media work
// [RULE_21] sticky error flag identifies violation
package media_seq_pkg;
  localparam logic [7:0] CMD_FLUSH = 8'h01;
  localparam logic [7:0] CMD_LOAD_REG = 8'h02;
  localparam logic [7:0] CMD_SETUP_STATE = 8'h03;
  localparam logic [7:0] CMD_SELECT = 8'h04;
  localparam logic [7:0] CMD_FENCE = 8'h05;
  localparam logic [7:0] CMD_BASE_ADDR = 8'h06;
  localparam logic [7:0] CMD_MEDIA_PTRS = 8'h07;
  localparam logic [7:0] CMD_STREAMER_STATE = 8'h08;
  localparam logic [7:0] CMD_FETCH_AHEAD = 8'h09;
  localparam logic [7:0] CMD_SYS_ROUTINE = 8'h0A;
  localparam logic [7:0] CMD_VERTEX_ELEM = 8'h0B;
  localparam logic [7:0] CMD_VERTEX_BUF = 8'h0C;
  localparam logic [7:0] CMD_CONST_BUF = 8'h0D;
  localparam logic [7:0] CMD_DRAW = 8'h0E;
  localparam logic [7:0] CMD_MEDIA_OBJ = 8'h0F;
  localparam logic [7:0] CMD_STATS_EN = 8'h10;
  localparam logic [31:0] VC_REG_ADDR = 32'h0000_2124;
  localparam logic [31:0] VC_DISABLE = 32'h1000_0000;
  localparam logic [31:0] VC_ENABLE = 32'h1000_1000;
  localparam logic [31:0] VB_PITCH = 32'h0000_0020;
  localparam logic [31:0] VE_FORMAT = 32'h0000_0002;
  localparam logic [31:0] VE_CTRL = 32'h0000_0001;
  localparam logic [31:0] VE1_OFFSET = 32'h0000_0010;
  localparam logic [31:0] TOPO_POINTS = 32'h0000_0001;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_ADDR = 12'h008;
  localparam logic [11:0] OFF_SIZE = 12'h00C;
  localparam logic [11:0] OFF_COUNT = 12'h010;
  localparam int CTRL_GO = 0;
  localparam int CTRL_OLDER = 1;
  localparam int CTRL_FROM3D = 2;
  localparam int CTRL_INDIRECT = 3;
  localparam int CTRL_NEWCTX = 4;
  localparam int CTRL_CSENTRY = 5;
  localparam int CTRL_MIXED = 6;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ERR = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int NUM_STEPS = 20;
  typedef struct packed {
    logic [7:0] op;
    logic [31:0] arg0;
    logic [31:0] arg1;
  } cmd_s;
endpackage

// *** verif/media_command_sequence_checker_tb.sv ***
// self-checking bench for the media command stream issuer
`timescale 1ns/1ps
module media_command_sequence_checker_tb;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic cmd_valid, cmd_ready, clr, slow, new_ctx;
  media_seq_pkg::cmd_s cmd;
  logic [7:0] viol, objs;
  logic [31:0] vc;
  logic [33:0] notes[$];
  logic [33:0] e;
  logic [6:0] c;
  int error_cnt = 0;
  int compares = 0;
  media_seq_issuer dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .cmd_valid_o(cmd_valid), .cmd_o(cmd),
    .cmd_ready_i(cmd_ready));
  media_dev_model dev_u (.clk_i(clk_i), .rst_i(rst_i), .clr_i(clr),
    .slow_i(slow), .new_ctx_i(new_ctx), .cmd_valid_i(cmd_valid),
    .cmd_i(cmd), .cmd_ready_o(cmd_ready), .viol_o(viol),
    .obj_cnt_o(objs), .vc_reg_o(vc));
  initial clk_i = 1'b0;
  always #5 clk_i = ~clk_i;
  task automatic final_report;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] ex,
      input logic [31:0] got);
    compares++;
    if (ex !== got) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rq = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      final_report;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ex,
      input logic ck);
    notes.push_back({ck, a > media_seq_pkg::OFF_COUNT, ex});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // watcher takes the oldest note at each read answer
  always @(posedge clk_i) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      e = notes.pop_front();
      if (e[33]) begin
        chk("prdata", e[31:0], prdata);
        chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      end
    end
  end
  task automatic run(input logic [6:0] cv, input logic [31:0] sz,
      input logic [7:0] n, input logic ee);
    int k;
    @(posedge clk_i);
    clr <= 1'b1;
    new_ctx <= cv[media_seq_pkg::CTRL_NEWCTX];
    slow <= 1'($urandom % 2);
    @(posedge clk_i);
    clr <= 1'b0;
    wr(media_seq_pkg::OFF_ADDR, 32'h0001_0000);
    wr(media_seq_pkg::OFF_SIZE, sz);
    wr(media_seq_pkg::OFF_COUNT, {24'h0, n});
    rd(media_seq_pkg::OFF_COUNT, {24'h0, n}, 1'b1);
    wr(media_seq_pkg::OFF_CTRL, {25'h0, cv} | 32'h1);
    if (!ee) wr(media_seq_pkg::OFF_ADDR, 32'h0BAD_0000);
    k = 0;
    rq = 32'h1;
    while (rq[0] !== 1'b0 && k < 400) begin
      rd(media_seq_pkg::OFF_STATUS, 32'h0, 1'b0);
      k++;
    end
    if (k >= 400) begin
      error_cnt++;
      final_report;
    end
    rd(media_seq_pkg::OFF_STATUS, {30'h0, ee, 1'b0}, 1'b1);
    rd(media_seq_pkg::OFF_CTRL, {25'h0, cv}, 1'b1);
    if (ee) begin
      wr(media_seq_pkg::OFF_STATUS, 32'h2);
      rd(media_seq_pkg::OFF_STATUS, 32'h0, 1'b1);
    end else begin
      rd(media_seq_pkg::OFF_ADDR, 32'h0001_0000, 1'b1);
      chk("violations", 32'h0, {24'h0, viol});
      chk("objects", {24'h0, n}, {24'h0, objs});
      if (cv[media_seq_pkg::CTRL_OLDER])
        chk("vc_reg", cv[media_seq_pkg::CTRL_INDIRECT] ?
          media_seq_pkg::VC_ENABLE :
          media_seq_pkg::VC_DISABLE, vc);
    end
  endtask
  initial begin
    {psel, penable, pwrite, clr, slow, new_ctx} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    rst_i = 1'b1;
    void'($urandom(85));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(media_seq_pkg::OFF_CTRL, media_seq_pkg::CTRL_RESET, 1'b1);
    rd(media_seq_pkg::OFF_STATUS, 32'h0, 1'b1);
    rd(12'h0FC, 32'h0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      c = 7'h00;
      c[3:1] = 3'(i);
      c[6:4] = 3'($urandom % 8);
      run(c, 32'h20 * (32'h1 + $urandom % 4), 8'(1 + $urandom % 4), 1'b0);
    end
    // size not a multiple of 32 with indirect load
    run(7'h0A, 32'h21, 8'h2, 1'b1);
    run(7'h1A, 32'h40, 8'h3, 1'b0);
    final_report;
  end
endmodule // media_command_sequence_checker_tb

// *** verif/media_dev_model.sv ***
// behavioural model of the device that consumes the setup command stream
`timescale 1ns/1ps
module media_dev_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // run control
  input wire logic clr_i,
  input wire logic slow_i,
  input wire logic new_ctx_i,
  // command stream
  input wire logic cmd_valid_i,
  input wire media_seq_pkg::cmd_s cmd_i,
  output logic cmd_ready_o,
  // observations
  output logic [7:0] viol_o,
  output logic [7:0] obj_cnt_o,
  output logic [31:0] vc_reg_o
);
  logic [1:0] cnt;
  logic fl, sel, nf, pf, ba, sb, mp;
  logic [2:0] rk;
  logic [2:0] r;
  logic [1:0] fc;
  logic [1:0] cb;
  logic [7:0] op;
  // slow mode takes one command every fourth cycle
  assign cmd_ready_o = !slow_i || cnt == 2'h3;
  always @(posedge clk_i) begin
    if (rst_i) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  always @(posedge clk_i) begin
    if (rst_i || clr_i) begin
      {fl, sel, nf, pf, ba, sb, mp} = 7'h00;
      rk = 3'h0;
      fc = 2'h0;
      cb = 2'h0;
      viol_o = 8'h00;
      obj_cnt_o = 8'h00;
      if (rst_i) vc_reg_o = 32'h0000_0000;
    end else if (cmd_valid_i && cmd_ready_o) begin
      op = cmd_i.op;
      case (op)
        media_seq_pkg::CMD_FENCE: r = 3'h3;
        media_seq_pkg::CMD_CONST_BUF: r = 3'h5;
        media_seq_pkg::CMD_DRAW, media_seq_pkg::CMD_MEDIA_OBJ: r = 3'h6;
        default: r = 3'h4;
      endcase
      if (!fl && !(op inside {media_seq_pkg::CMD_FLUSH,
          media_seq_pkg::CMD_BASE_ADDR, media_seq_pkg::CMD_STATS_EN,
          media_seq_pkg::CMD_LOAD_REG})) viol_o++;
      if (sel && op != media_seq_pkg::CMD_SELECT) begin
        if (r < rk) viol_o++;
        rk = r;
        if (nf && op != media_seq_pkg::CMD_FENCE) viol_o++;
        nf = 1'b0;
        if (r == 3'h4 && op != media_seq_pkg::CMD_BASE_ADDR && !sb) viol_o++;
        if (op == media_seq_pkg::CMD_BASE_ADDR) sb = 1'b1;
      end
      case (op)
        media_seq_pkg::CMD_FLUSH: begin
          fl = 1'b1;
          cb = 2'h0;
          if (sel) viol_o++;
        end
        media_seq_pkg::CMD_LOAD_REG:
          if (cmd_i.arg0 == media_seq_pkg::VC_REG_ADDR) vc_reg_o = cmd_i.arg1;
        media_seq_pkg::CMD_SETUP_STATE: if (sel) viol_o++;
        media_seq_pkg::CMD_FENCE: begin
          if (sel) fc++;
          else pf = 1'b1;
          if (fc > 2'h1) viol_o++;
        end
        media_seq_pkg::CMD_SELECT: begin
          if (new_ctx_i && !(pf && ba)) viol_o++;
          sel = 1'b1;
          nf = 1'b1;
        end
        media_seq_pkg::CMD_BASE_ADDR: ba = 1'b1;
        media_seq_pkg::CMD_MEDIA_PTRS: mp = 1'b1;
        media_seq_pkg::CMD_CONST_BUF: begin
          cb++;
          if (cb > 2'h1) viol_o++;
        end
        media_seq_pkg::CMD_MEDIA_OBJ: begin
          if (!mp || !sb) viol_o++;
          obj_cnt_o++;
        end
        default: ;
      endcase
    end
  end
endmodule // media_dev_model
